// >>> src/apl_ctrl.sv
// Auto polarity reversing half-duplex line transceiver control
// Operation
// - Both enables low and receive low for wait time swaps line polarity.
// - Normal polarity after power-up and until reversal condition is met.
// - Fail-safe high receive also holds in reversed polarity.
// - Receive output high when differential at or above upper threshold.
// - Receive output low when differential at or below lower threshold.
// - Open, shorted or idle terminated line yields high receive output.
// - During power-up, driver enable forced low and receiver enable forced off.
// - Receiver off and driver off together enter low-power shutdown.
// - Shutdown combination shorter than minimum filter time never enters shutdown.
// - Shutdown combination lasting maximum filter time always enters shutdown.
// - Enabling from shutdown incurs an extra wake-up delay.
// - Over-temperature forces both driver outputs to high impedance.
// - Driver enabled drives A as data, B complement; else both released.
// - Receiver enable low drives receive output, high releases it.
// - Normal polarity maps line two to A; reversed swaps both directions.
`timescale 1ns/1ps

module apl_ctrl
  import apl_pkg::*;
#(
  parameter longint FLIP_CYC = FLIP_WAIT_CYC,
  parameter int PWRUP_HOLD = PWRUP_CYC,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,

  // Enable pins and thermal flag (asynchronous)
  input wire logic tx_drive_on,
  input wire logic rx_on_low,
  input wire logic over_temp,

  // Transmit bit stream from local controller
  input wire logic tx_bit_in,
  input wire logic tx_bit_valid,
  output logic tx_bit_ready,

  // Line differential, signed mV, from the line comparator
  input wire logic signed [DIFF_W-1:0] line_diff_volt,

  // Receive output pin
  output logic rx_bit_out,
  output logic rx_bit_oe,

  // Bus lines
  output apl_bus_t bus_drive,

  // Status
  output logic polarity_rev,
  output logic in_shutdown
);

  localparam int FLIP_W = $clog2(FLIP_CYC + 1);
  localparam int PW_W = $clog2(PWRUP_HOLD + 1);
  localparam int WK_W = $clog2(WAKE_DRV_CYC + 1);
  localparam int SF_W = $clog2(SHDN_MAX_CYC + 1);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  // Polarity-corrected differential
  function automatic logic signed [DIFF_W:0] apl_orient(
    input logic signed [DIFF_W-1:0] v,
    input logic rev
  );
    logic signed [DIFF_W:0] w;
    w = {v[DIFF_W-1], v};
    apl_orient = rev ? -w : w;
  endfunction

  // Pointer advance with wrap
  function automatic logic [PTR_W-1:0] apl_next(input logic [PTR_W-1:0] p);
    apl_next = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  // Two-stage synchronisers for pin inputs
  apl_ctl_t ctl_m_q;
  apl_ctl_t ctl_s_q;
  logic signed [DIFF_W-1:0] diff_m_q;
  logic signed [DIFF_W-1:0] diff_s_q;

  // The differential is slow and settles well before sampling; a
  // fast swing across two captures may give one odd word, then recovers.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_m_q <= '{drive_on: 1'h0, rx_low: 1'h1, hot: 1'h0};
      ctl_s_q <= '{drive_on: 1'h0, rx_low: 1'h1, hot: 1'h0};
      diff_m_q <= '0;
      diff_s_q <= '0;
    end else begin
      ctl_m_q <= '{drive_on: tx_drive_on, rx_low: rx_on_low, hot: over_temp};
      ctl_s_q <= ctl_m_q;
      diff_m_q <= line_diff_volt;
      diff_s_q <= diff_m_q;
    end
  end

  // Power-up hold
  logic [PW_W-1:0] pwr_cnt_q;
  logic pwr_done;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_cnt_q <= '0;
    end else if (!pwr_done) begin
      pwr_cnt_q <= pwr_cnt_q + PW_W'(1);
    end
  end

  assign pwr_done = (pwr_cnt_q == PW_W'(PWRUP_HOLD));

  // Effective enables: forced off until power-up completes
  logic de_eff;
  logic re_off_eff;
  assign de_eff = pwr_done & ctl_s_q.drive_on;
  assign re_off_eff = !pwr_done | ctl_s_q.rx_low;

  // Shutdown filter and wake-up sequencing
  apl_state_t state_q;
  logic [SF_W-1:0] shdn_cnt_q;
  logic [WK_W-1:0] wake_cnt_q;
  logic shdn_req;
  assign shdn_req = re_off_eff & !de_eff;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shdn_cnt_q <= '0;
    end else if (!shdn_req) begin
      shdn_cnt_q <= '0;
    end else if (shdn_cnt_q != SF_W'(SHDN_MAX_CYC)) begin
      shdn_cnt_q <= shdn_cnt_q + SF_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= APL_PWRUP;
    end else begin
      case (state_q)
        APL_PWRUP: begin
          if (pwr_done) begin
            state_q <= APL_RUN;
          end
        end
        APL_RUN: begin
          // Filter at the minimum keeps entry far below the upper limit
          if (shdn_req && shdn_cnt_q >= SF_W'(SHDN_MIN_CYC)) begin
            state_q <= APL_SHDN;
          end
        end
        APL_SHDN: begin
          if (!shdn_req) begin
            state_q <= APL_WAKE;
          end
        end
        APL_WAKE: begin
          if (shdn_req && shdn_cnt_q >= SF_W'(SHDN_MIN_CYC)) begin
            state_q <= APL_SHDN;
          end else if (wake_cnt_q == WK_W'(WAKE_DRV_CYC)) begin
            state_q <= APL_RUN;
          end
        end
        default: begin
          state_q <= APL_PWRUP;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wake_cnt_q <= '0;
    end else if (state_q != APL_WAKE) begin
      wake_cnt_q <= '0;
    end else if (wake_cnt_q != WK_W'(WAKE_DRV_CYC)) begin
      wake_cnt_q <= wake_cnt_q + WK_W'(1);
    end
  end

  logic drv_awake;
  logic rx_awake;
  assign drv_awake = (state_q == APL_RUN) ||
                     (state_q == APL_WAKE && wake_cnt_q >= WK_W'(WAKE_DRV_CYC));
  assign rx_awake = (state_q == APL_RUN) ||
                    (state_q == APL_WAKE && wake_cnt_q >= WK_W'(WAKE_RX_CYC));

  // Receive decision with hysteresis between the thresholds
  logic rev_q;
  logic rx_dec_q;
  logic signed [DIFF_W:0] diff_eff;
  assign diff_eff = apl_orient(diff_s_q, rev_q);

  // Idle, open or shorted lines sit near 0 mV, above the upper threshold
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_dec_q <= RX_BIT_RST;
    end else if (diff_eff >= (DIFF_W+1)'(RX_HI_MV)) begin
      rx_dec_q <= 1'h1;
    end else if (diff_eff <= (DIFF_W+1)'(RX_LO_MV)) begin
      rx_dec_q <= 1'h0;
    end
  end

  // Polarity reversal timer
  logic [FLIP_W-1:0] flip_cnt_q;
  logic flip_arm;
  logic flip_hit;
  assign flip_arm = pwr_done & !ctl_s_q.drive_on & !ctl_s_q.rx_low & !rx_dec_q;
  assign flip_hit = flip_arm && (flip_cnt_q == FLIP_W'(FLIP_CYC - 1));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flip_cnt_q <= '0;
    end else if (!flip_arm || flip_hit) begin
      flip_cnt_q <= '0;
    end else begin
      flip_cnt_q <= flip_cnt_q + FLIP_W'(1);
    end
  end

  // A further full wait with the line still low swaps back, so a
  // wrong guess corrects itself on the next idle period.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rev_q <= 1'h0;
    end else if (flip_hit) begin
      rev_q <= !rev_q;
    end
  end

  // Two-entry transmit buffer
  logic buf_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] cnt_q;
  logic push;
  logic pop;
  logic drv_on;
  logic drv_bit_q;

  assign drv_on = de_eff & drv_awake & !ctl_s_q.hot;
  assign tx_bit_ready = (cnt_q != CNT_W'(DEPTH));
  assign push = tx_bit_valid & tx_bit_ready;
  assign pop = drv_on & (cnt_q != '0);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= apl_next(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= apl_next(rd_ptr_q);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + CNT_W'(1);
      end else if (pop && !push) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      buf_q[wr_ptr_q] <= tx_bit_in;
    end
  end

  // Last bit is held on the line while the buffer is empty
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      drv_bit_q <= DRV_BIT_RST;
    end else if (pop) begin
      drv_bit_q <= buf_q[rd_ptr_q];
    end
  end

  // Line drive mapping
  always_comb begin
    bus_drive.one_oe = drv_on;
    bus_drive.two_oe = drv_on;
    if (rev_q) begin
      bus_drive.one_o = drv_bit_q;
      bus_drive.two_o = !drv_bit_q;
    end else begin
      bus_drive.two_o = drv_bit_q;
      bus_drive.one_o = !drv_bit_q;
    end
  end

  assign rx_bit_out = rx_dec_q;
  assign rx_bit_oe = !re_off_eff & rx_awake;
  assign polarity_rev = rev_q;
  assign in_shutdown = (state_q == APL_SHDN);

endmodule

// >>> src/apl_pkg.sv
// Shared constants and types for the auto polarity line controller
package apl_pkg;

  // Clock period of mclk
  localparam int CLK_NS = 20;

  // Polarity reversal wait, in ms and derived cycles
  localparam int FLIP_WAIT_MS = 200;
  localparam longint FLIP_WAIT_CYC = longint'(FLIP_WAIT_MS) * 1000000 / CLK_NS;

  // Shutdown filter window limits
  localparam int SHDN_MIN_NS = 50;
  localparam int SHDN_MAX_NS = 600;
  localparam int SHDN_MIN_CYC = (SHDN_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SHDN_MAX_CYC = SHDN_MAX_NS / CLK_NS;

  // Wake-up delays after leaving shutdown
  localparam int WAKE_DRV_NS = 4500;
  localparam int WAKE_RX_NS = 3500;
  localparam int WAKE_DRV_CYC = WAKE_DRV_NS / CLK_NS;
  localparam int WAKE_RX_CYC = WAKE_RX_NS / CLK_NS;

  // Power-up hold of the enables, in cycles
  localparam int PWRUP_CYC = 16;

  // Receive thresholds in mV
  localparam int RX_HI_MV = -50;
  localparam int RX_LO_MV = -200;

  // Line differential width (signed mV)
  localparam int DIFF_W = 12;

  // Reset values
  localparam logic RX_BIT_RST = 1'h1;
  localparam logic DRV_BIT_RST = 1'h1;

  typedef enum logic [1:0] {
    APL_PWRUP = 2'h0,
    APL_RUN = 2'h1,
    APL_SHDN = 2'h2,
    APL_WAKE = 2'h3
  } apl_state_t;

  // Pin drive of both bus lines
  typedef struct packed {
    logic one_o;
    logic one_oe;
    logic two_o;
    logic two_oe;
  } apl_bus_t;

  // Enables and flags after synchronisation
  typedef struct packed {
    logic drive_on;
    logic rx_low;
    logic hot;
  } apl_ctl_t;

endpackage

// >>> sim/apl_checker.sv
// Port-level assertions for the line controller
`timescale 1ns/1ps
module apl_checker
  import apl_pkg::*;
#(
  parameter longint FLIP_CYC = FLIP_WAIT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Pins in
  input wire logic tx_drive_on,
  input wire logic rx_on_low,
  input wire logic over_temp,
  input wire logic signed [DIFF_W-1:0] line_diff_volt,
  // Pins out
  input wire logic rx_bit_out,
  input wire logic rx_bit_oe,
  input wire apl_bus_t bus_drive,
  input wire logic polarity_rev,
  input wire logic in_shutdown
);
  logic shdn_pin;
  logic drv_oe;
  int shdn_q;
  int idle_q;
  assign shdn_pin = rx_on_low && !tx_drive_on;
  assign drv_oe = bus_drive.one_oe || bus_drive.two_oe;
  // Runs of raw pin states; the design sees them late through its synchronisers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shdn_q <= 0;
    end else begin
      shdn_q <= shdn_pin ? shdn_q + 1 : 0;
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      idle_q <= 0;
    end else begin
      idle_q <= (!tx_drive_on && !rx_on_low && !rx_bit_out) ? idle_q + 1 : 0;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  AST_HOT_HIZ: assert property (over_temp [*4] |-> !drv_oe) else $error("driver on while hot");
  AST_DRV_OFF: assert property (!tx_drive_on [*4] |-> !drv_oe) else $error("driver on while disabled");
  AST_RX_OFF: assert property (rx_on_low [*4] |-> !rx_bit_oe) else $error("receive pin driven while off");
  AST_SHDN_MAX: assert property (shdn_q >= SHDN_MAX_CYC |-> in_shutdown) else $error("shutdown late");
  // Entry may land after the pins have already left the combination, so look back past the synchronisers
  AST_SHDN_MIN: assert property ($rose(in_shutdown) |-> $past(shdn_q, 2) >= 3)
    else $error("shutdown too early");
  AST_WAKE: assert property ($fell(in_shutdown) |-> (!drv_oe && !rx_bit_oe) [*8]) else $error("no wake delay");
  AST_RX_LO: assert property ((!in_shutdown && !polarity_rev && line_diff_volt <= RX_LO_MV) [*4] |-> !rx_bit_out)
    else $error("receive not low");
  AST_RX_HI: assert property ((!in_shutdown && !polarity_rev && line_diff_volt >= RX_HI_MV) [*4] |-> rx_bit_out)
    else $error("receive not high");
  AST_FAILSAFE: assert property ((!in_shutdown && line_diff_volt == 0) [*4] |-> rx_bit_out) else $error("idle low");
  // The pins may leave idle in the last two cycles of the wait, hidden by the synchronisers
  AST_POL: assert property ($changed(polarity_rev) |-> $past(idle_q, 2) >= FLIP_CYC - 3)
    else $error("early swap");
endmodule

// >>> sim/apl_line_model.sv
// Multidrop line with one remote node and termination
`timescale 1ns/1ps
module apl_line_model
  import apl_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Local and remote drive
  input wire apl_bus_t bus_drive,
  input wire logic far_en,
  input wire logic far_bit,
  // Differential, line two minus line one
  output logic signed [DIFF_W-1:0] line_diff_volt
);
  localparam logic signed [DIFF_W-1:0] SWING = 12'sh5DC;
  logic toggle_q = 1'h0;
  always @(posedge mclk) begin
    toggle_q <= !toggle_q;
  end
  always_comb begin
    if (bus_drive.two_oe && far_en) begin
      // Contention settles nowhere, so show a moving level
      line_diff_volt = toggle_q ? SWING : -SWING;
    end else if (bus_drive.two_oe) begin
      line_diff_volt = bus_drive.two_o ? SWING : -SWING;
    end else if (far_en) begin
      line_diff_volt = far_bit ? SWING : -SWING;
    end else begin
      // Released pair is pulled together by the termination
      line_diff_volt = '0;
    end
  end
endmodule

// >>> sim/apl_ctrl_bench.sv
// Self-checking bench for the line controller
`timescale 1ns/1ps
module apl_ctrl_bench;
  import apl_pkg::*;
  typedef struct packed {
    logic de, rl, hot, fe, fb, oe, rx_oe, rx;
  } apl_row_t;
  // Remote traffic keeps every low run short of the swap wait
  apl_row_t rows[6] = '{8'h87, 8'h12, 8'h1B, 8'h03, 8'hE1, 8'hC5};
  logic mclk, rst_b = 1'h0, tx_drive_on = 1'h1, rx_on_low = 1'h0, over_temp = 1'h0;
  logic tx_bit_in = 1'h1, tx_bit_valid = 1'h0, far_en = 1'h0, far_bit = 1'h0;
  logic tx_bit_ready, rx_bit_out, rx_bit_oe, polarity_rev, in_shutdown;
  logic signed [DIFF_W-1:0] line_diff_volt;
  apl_bus_t bus_drive;
  logic q[$];
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  apl_ctrl #(.FLIP_CYC(20), .PWRUP_HOLD(4)) apl_ctrl_inst (.mclk(mclk), .rst_b(rst_b), .tx_drive_on(tx_drive_on),
    .rx_on_low(rx_on_low), .over_temp(over_temp), .tx_bit_in(tx_bit_in), .tx_bit_valid(tx_bit_valid),
    .tx_bit_ready(tx_bit_ready), .line_diff_volt(line_diff_volt), .rx_bit_out(rx_bit_out), .rx_bit_oe(rx_bit_oe),
    .bus_drive(bus_drive), .polarity_rev(polarity_rev), .in_shutdown(in_shutdown));
  apl_line_model apl_line_model_inst (.mclk(mclk), .bus_drive(bus_drive), .far_en(far_en), .far_bit(far_bit),
    .line_diff_volt(line_diff_volt));
  task automatic chk(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Holds the offer until ready is seen high at an edge; caller drops valid
  task automatic push(input logic b);
    logic r;
    tx_bit_in <= b;
    tx_bit_valid <= 1'h1;
    do begin
      @(negedge mclk) r = tx_bit_ready;
      @(posedge mclk);
    end while (!r);
  endtask
  initial begin
    mclk = 1'h0;
    forever #10 mclk = !mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    tick(2);
    @(negedge mclk);
    chk("rx_bit_out", 1'h1, rx_bit_out);
    chk("polarity_rev", 1'h0, polarity_rev);
    chk("in_shutdown", 1'h0, in_shutdown);
    @(posedge mclk);
    rst_b <= 1'h1;
    tick(2);
    @(negedge mclk);
    chk("two_oe", 1'h0, bus_drive.two_oe);
    chk("rx_bit_oe", 1'h0, rx_bit_oe);
    foreach (rows[i]) begin
      @(posedge mclk);
      tx_drive_on <= rows[i].de;
      rx_on_low <= rows[i].rl;
      over_temp <= rows[i].hot;
      far_en <= rows[i].fe;
      far_bit <= rows[i].fb;
      tick(7);
      @(negedge mclk);
      chk("two_oe", rows[i].oe, bus_drive.two_oe);
      chk("one_oe", rows[i].oe, bus_drive.one_oe);
      chk("rx_bit_oe", rows[i].rx_oe, rx_bit_oe);
      chk("rx_bit_out", rows[i].rx, rx_bit_out);
    end
    @(posedge mclk);
    tx_drive_on <= 1'h0;
    rx_on_low <= 1'h0;
    tick(4);
    push(1'h0);
    push(1'h1);
    tx_bit_valid <= 1'h0;
    @(negedge mclk);
    chk("tx_bit_ready", 1'h0, tx_bit_ready);
    @(posedge mclk);
    tx_drive_on <= 1'h1;
    repeat (10) begin
      @(negedge mclk);
      if (bus_drive.two_oe && (q.size() == 0 || q[$] !== bus_drive.two_o)) q.push_back(bus_drive.two_o);
      if (bus_drive.two_oe) chk("one_o", !bus_drive.two_o, bus_drive.one_o);
    end
    chk("first bit", 1'h0, q[$-1]);
    chk("second bit", 1'h1, q[$]);
    @(posedge mclk);
    tx_drive_on <= 1'h0;
    rx_on_low <= 1'h1;
    tick(2);
    rx_on_low <= 1'h0;
    repeat (10) begin
      @(negedge mclk);
      chk("in_shutdown", 1'h0, in_shutdown);
    end
    @(posedge mclk);
    rx_on_low <= 1'h1;
    tick(SHDN_MAX_CYC);
    @(negedge mclk);
    chk("in_shutdown", 1'h1, in_shutdown);
    @(posedge mclk);
    tx_drive_on <= 1'h1;
    rx_on_low <= 1'h0;
    tick(20);
    @(negedge mclk);
    chk("two_oe", 1'h0, bus_drive.two_oe);
    chk("rx_bit_oe", 1'h0, rx_bit_oe);
    tick(WAKE_RX_CYC);
    @(negedge mclk);
    chk("rx_bit_oe", 1'h1, rx_bit_oe);
    chk("two_oe", 1'h0, bus_drive.two_oe);
    tick(WAKE_DRV_CYC - WAKE_RX_CYC);
    @(negedge mclk);
    chk("two_oe", 1'h1, bus_drive.two_oe);
    @(posedge mclk);
    tx_drive_on <= 1'h0;
    far_en <= 1'h1;
    far_bit <= 1'h0;
    tick(12);
    far_bit <= 1'h1;
    tick(2);
    far_bit <= 1'h0;
    tick(12);
    @(negedge mclk);
    chk("polarity_rev", 1'h0, polarity_rev);
    tick(20);
    @(negedge mclk);
    chk("polarity_rev", 1'h1, polarity_rev);
    chk("rx_bit_out", 1'h1, rx_bit_out);
    @(posedge mclk);
    far_en <= 1'h0;
    push(1'h0);
    tx_bit_valid <= 1'h0;
    tick(6);
    @(negedge mclk);
    chk("rx_bit_out", 1'h1, rx_bit_out);
    @(posedge mclk);
    tx_drive_on <= 1'h1;
    tick(6);
    @(negedge mclk);
    chk("one_o", 1'h0, bus_drive.one_o);
    chk("two_o", 1'h1, bus_drive.two_o);
    tally_and_finish();
  end
endmodule
bind apl_ctrl apl_checker #(.FLIP_CYC(FLIP_CYC)) apl_checker_inst (.mclk(mclk), .rst_b(rst_b),
  .tx_drive_on(tx_drive_on), .rx_on_low(rx_on_low), .over_temp(over_temp), .line_diff_volt(line_diff_volt),
  .rx_bit_out(rx_bit_out), .rx_bit_oe(rx_bit_oe), .bus_drive(bus_drive), .polarity_rev(polarity_rev),
  .in_shutdown(in_shutdown));
